// ==== include/cif_pkg.sv ====
/*
  Constants for the camera I/O filter and strobe block: node ids, field
  codes, reset values, raw ranges and timebase steps.
  Assumes a 50 MHz core clock; raw units are 10 ns or 8 ns ticks.
*/
`default_nettype none
package cif_pkg;
  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned GLITCH_TICK_NS = 10;
  localparam int unsigned LOCK_TICK_NS   = 8;
  // Integration counter advances in raw units per clock
  localparam logic [18:0] GLITCH_STEP = 19'(CLK_PERIOD_NS / GLITCH_TICK_NS);
  // 8 ns counters advance in half raw units per clock (20 ns = 2.5 ticks)
  localparam logic [4:0]  HALF_STEP   = 5'(2 * CLK_PERIOD_NS / LOCK_TICK_NS);

  // ----------------------------------------------------------------
  // Node ids
  // ----------------------------------------------------------------
  localparam logic [3:0] ID_POLARITY = 4'h0;
  localparam logic [3:0] ID_LEVEL    = 4'h1;
  localparam logic [3:0] ID_USER     = 4'h2;
  localparam logic [3:0] ID_POINTER  = 4'h3;
  localparam logic [3:0] ID_ORIGIN   = 4'h4;
  localparam logic [3:0] ID_MODE     = 4'h5;
  localparam logic [3:0] ID_INTEG    = 4'h6;
  localparam logic [3:0] ID_LOCKOUT  = 4'h7;
  localparam logic [3:0] ID_TIMER    = 4'h8;
  localparam logic [3:0] ID_DELAY    = 4'h9;
  localparam logic [3:0] ID_LENGTH   = 4'hA;
  localparam logic [3:0] ID_START    = 4'hB;

  // ----------------------------------------------------------------
  // Field codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_OFF    = 3'h0;
  localparam logic [2:0] SRC_USER   = 3'h1;
  localparam logic [2:0] SRC_STROBE = 3'h2;
  localparam logic [2:0] SRC_ACQ    = 3'h3;
  localparam logic [2:0] SRC_TWAIT  = 3'h4;
  localparam logic [2:0] SRC_FRAME  = 3'h5;
  localparam logic [2:0] SRC_XFER   = 3'h6;
  localparam logic [2:0] SRC_EXPO   = 3'h7;
  localparam logic [1:0] START_OFF   = 2'h0;
  localparam logic [1:0] START_LINE0 = 2'h1;
  localparam logic [1:0] START_FTRIG = 2'h2;
  localparam logic [1:0] START_EXPO  = 2'h3;
  localparam logic [2:0] LINE_ZERO  = 3'h0;
  localparam logic [2:0] LINE_TWO   = 3'h2;
  localparam logic [2:0] LINE_THREE = 3'h3;
  localparam logic [2:0] LINE_FOUR  = 3'h4;
  localparam logic [4:0]  MODE_FIXED  = 5'h18;
  localparam logic [31:0] TIMER_NAME  = 32'h0;
  localparam logic [4:0]  POL_RST     = 5'h00;
  localparam logic [17:0] GLITCH_MIN  = 18'h00009;
  localparam logic [17:0] GLITCH_MAX  = 18'h30D40;
  localparam logic [17:0] LOCK_MIN    = 18'h000F9;
  localparam logic [17:0] LOCK_MAX    = 18'h3D08F;
  localparam logic [27:0] STROBE_MAX  = 28'hEE6B280;
  localparam logic [27:0] STROBE_RST  = 28'h0000000;

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp
endpackage : cif_pkg
`default_nettype wire

// ==== logic/cif_io_strobe.sv ====
/*
  Camera digital I/O: line polarity, level readback, output source
  selection for lines 3 and 4, trigger integration and lockout filters,
  and the strobe pulse timer.
  Assumes all inputs synchronous to ref_clk_i; camera state signals and
  the trigger delay come from the acquisition logic outside.
*/
// Summary of operation
// - Five-bit polarity mask, one bit per line, set inverts, resets to zero.
// - Read-only level word: bit n is line n, one means high; input bits are inverted when their polarity bit is set.
// - User output word bits three and four drive lines three and four.
// - Line pointer selects line zero, one, three or four, never two.
// - Output sources: off, user, strobe, acquisition, trigger wait, frame, transfer, exposure.
// - User source drives the line with its user output word bit.
// - Acquisition source is high while acquisition is started.
// - Trigger wait source is high while a new trigger can be accepted.
// - Frame source is high from exposure start until readout completes.
// - Transfer source is high while image data moves on the host bus.
// - Exposure source is high from exposure start to exposure end.
// - Lines zero and one are inputs only, three and four outputs only.
// - Trigger input is integrated; raw/100 us, range 9 to 200000, reset 9.
// - Edges during lockout wait until it ends; raw/125 us, range 249 to 249999, reset 249.
// - Strobe delay and length in raw/125 us, 0 to 250000000, reset 0.
// - Strobe start: off, line zero active, frame trigger, or exposure start.
// - Line zero start needs hardware mode and fires on rejected triggers.
// - Strobe starts after trigger delay plus timer delay.
// - Timer selector is read-only and names the single timer.
// - Trigger delay counts for hardware and software triggers, raw/125 us.
`timescale 1ns/1ns
`default_nettype none
module cif_io_strobe
  import cif_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [4:0]  line_in_i,
  input  wire logic        capture_running_flag_i,
  input  wire logic        trigger_accept_ready_i,
  input  wire logic        exposure_to_readout_window_i,
  input  wire logic        image_transfer_window_i,
  input  wire logic        exposure_window_i,
  input  wire logic        start_of_frame_request_i,
  input  wire logic        shutter_open_event_i,
  input  wire logic        rejected_trigger_fault_i,
  input  wire logic        hw_trigger_mode_i,
  input  wire logic [27:0] pre_exposure_wait_i,
  input  wire logic        node_wr_i,
  input  wire logic        node_rd_i,
  input  wire logic [3:0]  node_id_i,
  input  wire logic [31:0] node_wdata_i,
  output logic [31:0]      node_rdata_o,
  output logic             node_rvalid_o,
  output logic             line3_o,
  output logic             line4_o,
  output logic             trig_filtered_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_PULSE} cif_strobe_e;

  typedef struct packed {
    logic [4:0]  pol;
    logic [1:0]  user;
    logic [2:0]  ptr;
    logic [2:0]  src3;
    logic [2:0]  src4;
    logic [17:0] glitch_raw;
    logic [17:0] lock_raw;
    logic [27:0] dly_raw;
    logic [27:0] len_raw;
    logic [1:0]  start_sel;
    logic [18:0] g_cnt;
    logic        g_lvl;
    logic        filt;
    logic        locked;
    logic [19:0] l_cnt;
    cif_strobe_e st;
    logic [30:0] s_cnt;
    logic        strobe;
    logic        line3;
    logic        line4;
    logic [31:0] rdata;
    logic        rvalid;
  } cif_state_s;

  cif_state_s s;
  cif_state_s next_s;

  logic        trig_in;
  logic        mism;
  logic        start_evt;
  logic [4:0]  level_word;
  logic [30:0] dly_target;
  logic [28:0] dly_sum;
  logic [18:0] g_sum;
  logic [19:0] l_sum;
  logic [30:0] s_sum;

  function automatic logic pick(input logic [2:0] sel, input logic usr, input logic stb);
    case (sel)
      SRC_USER:   pick = usr;
      SRC_STROBE: pick = stb;
      SRC_ACQ:    pick = capture_running_flag_i;
      SRC_TWAIT:  pick = trigger_accept_ready_i;
      SRC_FRAME:  pick = exposure_to_readout_window_i;
      SRC_XFER:   pick = image_transfer_window_i;
      SRC_EXPO:   pick = exposure_window_i;
      default:    pick = 1'b0;
    endcase
  endfunction : pick

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s     = s;
    trig_in    = line_in_i[0] ^ s.pol[0];
    mism       = trig_in != s.g_lvl;
    level_word = {s.line4, s.line3, line_in_i[2:0] ^ s.pol[2:0]};
    g_sum      = s.g_cnt + GLITCH_STEP;
    l_sum      = s.l_cnt + 20'(HALF_STEP);
    s_sum      = s.s_cnt + 31'(HALF_STEP);
    // Both delays share the 8 ns raw unit, so they add before doubling
    dly_sum    = {1'b0, pre_exposure_wait_i} + {1'b0, s.dly_raw};
    dly_target = {1'b0, dly_sum, 1'b0};

    // Integration: level moves only after a mismatch lasts the full time
    if (!mism) begin
      next_s.g_cnt = '0;
    end else if (g_sum >= {1'b0, s.glitch_raw}) begin
      next_s.g_lvl = trig_in;
      next_s.g_cnt = '0;
    end else begin
      next_s.g_cnt = g_sum;
    end

    // Lockout: first edge passes, later ones wait out the window
    start_evt = 1'b0;
    if (s.locked) begin
      if (l_sum >= {1'b0, s.lock_raw, 1'b0}) begin
        next_s.locked = 1'b0;
        next_s.l_cnt  = '0;
      end else begin
        next_s.l_cnt = l_sum;
      end
    end else if (s.g_lvl != s.filt) begin
      next_s.filt   = s.g_lvl;
      next_s.locked = 1'b1;
      next_s.l_cnt  = '0;
    end

    // Strobe start event; line zero fires even if the trigger is rejected
    case (s.start_sel)
      START_LINE0: start_evt = hw_trigger_mode_i && !s.locked && s.g_lvl && !s.filt;
      START_FTRIG: start_evt = start_of_frame_request_i && !rejected_trigger_fault_i;
      START_EXPO:  start_evt = shutter_open_event_i;
      default:     start_evt = 1'b0;
    endcase

    // Retriggers while a pulse is pending or active are dropped
    case (s.st)
      ST_IDLE: begin
        if (start_evt) begin
          next_s.st    = ST_WAIT;
          next_s.s_cnt = '0;
        end
      end
      ST_WAIT: begin
        if (s.s_cnt >= dly_target) begin
          next_s.st    = (s.len_raw == STROBE_RST) ? ST_IDLE : ST_PULSE;
          next_s.s_cnt = '0;
        end else begin
          next_s.s_cnt = s_sum;
        end
      end
      ST_PULSE: begin
        if (s_sum >= {2'b00, s.len_raw, 1'b0}) begin
          next_s.st    = ST_IDLE;
          next_s.s_cnt = '0;
        end else begin
          next_s.s_cnt = s_sum;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
    next_s.strobe = next_s.st == ST_PULSE;

    // Output lines carry the chosen source, inverted when their polarity bit is set
    next_s.line3 = pick(s.src3, s.user[0], s.strobe) ^ s.pol[3];
    next_s.line4 = pick(s.src4, s.user[1], s.strobe) ^ s.pol[4];

    // Node reads
    next_s.rvalid = node_rd_i;
    if (node_rd_i) begin
      case (node_id_i)
        ID_POLARITY: next_s.rdata = {27'h0, s.pol};
        ID_LEVEL:    next_s.rdata = {27'h0, level_word};
        ID_USER:     next_s.rdata = {27'h0, s.user, 3'h0};
        ID_POINTER:  next_s.rdata = {29'h0, s.ptr};
        ID_ORIGIN:   next_s.rdata = {29'h0, (s.ptr == LINE_THREE) ? s.src3 :
                                            (s.ptr == LINE_FOUR) ? s.src4 : SRC_OFF};
        ID_MODE:     next_s.rdata = {27'h0, MODE_FIXED};
        ID_INTEG:    next_s.rdata = {14'h0, s.glitch_raw};
        ID_LOCKOUT:  next_s.rdata = {14'h0, s.lock_raw};
        ID_TIMER:    next_s.rdata = TIMER_NAME;
        ID_DELAY:    next_s.rdata = {4'h0, s.dly_raw};
        ID_LENGTH:   next_s.rdata = {4'h0, s.len_raw};
        ID_START:    next_s.rdata = {30'h0, s.start_sel};
        default:     next_s.rdata = 32'h0;
      endcase
    end

    // Node writes; out-of-range times are clamped to their limits
    if (node_wr_i) begin
      case (node_id_i)
        ID_POLARITY: next_s.pol  = node_wdata_i[4:0];
        ID_USER:     next_s.user = node_wdata_i[4:3];
        ID_POINTER: begin
          if (node_wdata_i[31:3] == 29'h0 && node_wdata_i[2:0] != LINE_TWO &&
              node_wdata_i[2:0] <= LINE_FOUR) begin
            next_s.ptr = node_wdata_i[2:0];
          end
        end
        ID_ORIGIN: begin
          // Input-only lines take no source
          if (s.ptr == LINE_THREE) begin
            next_s.src3 = node_wdata_i[2:0];
          end else if (s.ptr == LINE_FOUR) begin
            next_s.src4 = node_wdata_i[2:0];
          end
        end
        ID_INTEG:   next_s.glitch_raw = 18'(clamp(node_wdata_i, 32'(GLITCH_MIN), 32'(GLITCH_MAX)));
        ID_LOCKOUT: next_s.lock_raw   = 18'(clamp(node_wdata_i, 32'(LOCK_MIN), 32'(LOCK_MAX)));
        ID_DELAY:   next_s.dly_raw    = 28'(clamp(node_wdata_i, 32'(STROBE_RST), 32'(STROBE_MAX)));
        ID_LENGTH:  next_s.len_raw    = 28'(clamp(node_wdata_i, 32'(STROBE_RST), 32'(STROBE_MAX)));
        ID_START:   next_s.start_sel  = node_wdata_i[1:0];
        default:    next_s.pol        = s.pol;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s            <= '0;
      s.pol        <= POL_RST;
      s.glitch_raw <= GLITCH_MIN;
      s.lock_raw   <= LOCK_MIN;
      s.dly_raw    <= STROBE_RST;
      s.len_raw    <= STROBE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign node_rdata_o    = s.rdata;
  assign node_rvalid_o   = s.rvalid;
  assign line3_o         = s.line3;
  assign line4_o         = s.line4;
  assign trig_filtered_o = s.filt;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  polarity_store_a: assert property (node_wr_i && node_id_i == ID_POLARITY |=>
    s.pol == $past(node_wdata_i[4:0])) else $error("polarity mask not stored");
  level_read_a: assert property (node_rd_i && node_id_i == ID_LEVEL |=>
    node_rvalid_o && node_rdata_o == {27'h0, $past(level_word)}) else $error("level word wrong");
  pointer_legal_a: assert property (s.ptr != LINE_TWO && s.ptr <= LINE_FOUR)
    else $error("line pointer on an illegal line");
  user_drive_a: assert property (s.src3 == SRC_USER |=>
    line3_o == ($past(s.user[0]) ^ $past(s.pol[3]))) else $error("user level not on line 3");
  acq_drive_a: assert property (s.src4 == SRC_ACQ |=>
    line4_o == $past(capture_running_flag_i ^ s.pol[4])) else $error("acquisition not on line 4");
  input_fixed_a: assert property (node_wr_i && node_id_i == ID_ORIGIN && s.ptr < LINE_THREE |=>
    $stable(s.src3) && $stable(s.src4)) else $error("input line took a source");
  glitch_hold_a: assert property ($changed(s.g_lvl) |-> $past(mism, 1) && $past(mism, 2) &&
    $past(mism, 3) && $past(mism, 4) && $past(mism, 5)) else $error("glitch passed the filter");
  lockout_hold_a: assert property ($rose(s.locked) |-> s.locked [*8])
    else $error("lockout ended too early");
  start_off_a: assert property (s.start_sel == START_OFF && s.st == ST_IDLE |=> s.st == ST_IDLE)
    else $error("strobe started while off");
  strobe_delay_a: assert property ($rose(s.strobe) |-> $past(s.st) == ST_WAIT &&
    $past(s.s_cnt) >= $past(dly_target)) else $error("strobe before its delay");
  timer_name_a: assert property (node_rd_i && node_id_i == ID_TIMER |=>
    node_rdata_o == TIMER_NAME) else $error("timer name wrong");

endmodule : cif_io_strobe
`default_nettype wire

// ==== dv/cif_trigger_lamp.sv ====
/*
  Far-side model: a trigger source on lines 0 and 1 and a strobe lamp
  watching one camera output line.
  Assumes the bench sets the trigger levels and samples the lamp counts.
*/
`timescale 1ns/1ns
`default_nettype none
module cif_trigger_lamp (
  input  wire logic       clk_i,
  input  wire logic       fire_i,
  input  wire logic       aux_i,
  input  wire logic       lamp_i,
  output logic [4:0]      line_o,
  output int              flashes_o,
  output int              width_o
);
  int run;

  // Lines 3 and 4 are camera outputs; their input side is tied low here
  assign line_o = {3'b000, aux_i, fire_i};

  // ------------------------------------------------------------------
  // Lamp: a flash is counted when it ends, so its width is complete
  // ------------------------------------------------------------------
  // Two-state counters start at zero, so one process drives each of them
  always @(posedge clk_i) begin
    if (lamp_i === 1'b1) begin
      run <= run + 1;
    end else if (run > 0) begin
      flashes_o <= flashes_o + 1;
      width_o <= run;
      run <= 0;
    end
  end
endmodule : cif_trigger_lamp
`default_nettype wire

// ==== dv/camera_io_filter_strobe_bench.sv ====
/*
  Self-checking bench for cif_io_strobe: node access, line sources,
  trigger filter and strobe timer.
  Assumes the lamp model cif_trigger_lamp on line 3.
*/
`timescale 1ns/1ns
`default_nettype none
module camera_io_filter_strobe_bench;
  import cif_pkg::*;
  logic        ref_clk = 1'b0, reset_n = 1'b0, fire = 1'b0, aux = 1'b0, hw_mode = 1'b0;
  logic        sof = 1'b0, sho = 1'b0, rej = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        rvalid, line3, line4, trig;
  logic [4:0]  st = 5'h00, line_in;
  logic [27:0] tdly = 28'h0000000;
  logic [3:0]  id = 4'h0;
  logic [31:0] wd = 32'h0, rdata, rv;
  int          flashes, width, n, bad_count = 0, check_count = 0;
  logic [3:0]  ids [9] = '{ID_POLARITY, ID_INTEG, ID_LOCKOUT, ID_DELAY, ID_LENGTH, ID_TIMER, ID_MODE, ID_START, 4'hF};
  logic [31:0] rst [9] = '{32'h0, 32'h9, 32'hF9, 32'h0, 32'h0, 32'h0, 32'h18, 32'h0, 32'h0};
  logic [31:0] wv [9] = '{32'h1E, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h7, 32'h5, 32'h0, 32'h2, 32'h5};
  logic [31:0] ex [9] = '{32'h1E, 32'h9, 32'h3D08F, 32'hEE6B280, 32'h7, 32'h0, 32'h18, 32'h2, 32'h0};

  cif_io_strobe DUT (.ref_clk_i(ref_clk), .reset_n_i(reset_n), .line_in_i(line_in),
    .capture_running_flag_i(st[0]), .trigger_accept_ready_i(st[1]), .exposure_to_readout_window_i(st[2]),
    .image_transfer_window_i(st[3]), .exposure_window_i(st[4]), .start_of_frame_request_i(sof),
    .shutter_open_event_i(sho), .rejected_trigger_fault_i(rej), .hw_trigger_mode_i(hw_mode),
    .pre_exposure_wait_i(tdly), .node_wr_i(wr), .node_rd_i(rd), .node_id_i(id), .node_wdata_i(wd),
    .node_rdata_o(rdata), .node_rvalid_o(rvalid), .line3_o(line3), .line4_o(line4), .trig_filtered_o(trig));
  cif_trigger_lamp lamp (.clk_i(ref_clk), .fire_i(fire), .aux_i(aux), .lamp_i(line3), .line_o(line_in),
    .flashes_o(flashes), .width_o(width));

  always #10 ref_clk = ~ref_clk;

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int c);
    repeat (c) @(negedge ref_clk);
  endtask : cyc
  task automatic wnode(input logic [3:0] i, input logic [31:0] d);
    @(negedge ref_clk);
    wr = 1'b1;
    id = i;
    wd = d;
    @(negedge ref_clk);
    wr = 1'b0;
  endtask : wnode
  task automatic rnode(input logic [3:0] i);
    @(negedge ref_clk);
    rd = 1'b1;
    id = i;
    rv = 32'hDEADBEEF;
    for (int k = 0; k < 4; k++) begin
      @(negedge ref_clk);
      rd = 1'b0;
      if (rvalid === 1'b1) begin
        rv = rdata;
        break;
      end
    end
  endtask : rnode
  task automatic evt(input logic expo, input logic fault);
    @(negedge ref_clk);
    sof = ~expo;
    sho = expo;
    rej = fault;
    @(negedge ref_clk);
    sof = 1'b0;
    sho = 1'b0;
    rej = 1'b0;
  endtask : evt
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    for (int k = 0; k < 9; k++) begin
      rnode(ids[k]);
      check("reset value", rv, rst[k]);
      wnode(ids[k], wv[k]);
      rnode(ids[k]);
      check("written value", rv, ex[k]);
    end
    wnode(ID_POLARITY, 32'h0);
    wnode(ID_LOCKOUT, 32'hF9);
    wnode(ID_DELAY, 32'h0);
    wnode(ID_START, 32'h0);
  endtask : t_regs

  task automatic t_lines();
    // An input-only line must not pass its source write to line 3
    wnode(ID_POINTER, 32'h1);
    wnode(ID_ORIGIN, 32'(SRC_USER));
    wnode(ID_POINTER, 32'h3);
    rnode(ID_ORIGIN);
    check("origin after input write", rv, 32'(SRC_OFF));
    wnode(ID_ORIGIN, 32'(SRC_USER));
    wnode(ID_POINTER, 32'h4);
    wnode(ID_ORIGIN, 32'(SRC_USER));
    wnode(ID_USER, 32'h10);
    cyc(3);
    check("user lines", 32'({line4, line3}), 32'h2);
    wnode(ID_USER, 32'h08);
    cyc(3);
    check("user lines", 32'({line4, line3}), 32'h1);
    // A refused pointer keeps line 4 selected
    wnode(ID_POINTER, 32'h2);
    rnode(ID_POINTER);
    check("line pointer", rv, 32'h4);
    wnode(ID_ORIGIN, 32'(SRC_OFF));
    wnode(ID_USER, 32'h18);
    wnode(ID_POLARITY, 32'h1A);
    cyc(3);
    check("inverted lines", 32'({line4, line3}), 32'h2);
    rnode(ID_LEVEL);
    check("level word", rv, 32'h12);
    aux = 1'b1;
    rnode(ID_LEVEL);
    check("level word", rv, 32'h10);
    aux = 1'b0;
    wnode(ID_POLARITY, 32'h0);
  endtask : t_lines

  task automatic t_sources();
    // Line 4 follows the acquisition state throughout
    wnode(ID_POINTER, 32'h4);
    wnode(ID_ORIGIN, 32'(SRC_ACQ));
    wnode(ID_POINTER, 32'h3);
    for (int k = 0; k < 5; k++) begin
      wnode(ID_ORIGIN, 32'(SRC_ACQ + 3'(k)));
      st = 5'(1 << k);
      cyc(2);
      check("source high", 32'(line3), 32'h1);
      check("acq line 4", 32'(line4), 32'(st[0]));
      st = ~5'(1 << k);
      cyc(2);
      check("source low", 32'(line3), 32'h0);
      check("acq line 4", 32'(line4), 32'(st[0]));
    end
    wnode(ID_ORIGIN, 32'(SRC_OFF));
    cyc(2);
    check("source off", 32'(line3), 32'h0);
    st = 5'h00;
  endtask : t_sources

  task automatic t_filter();
    fire = 1'b1;
    cyc(3);
    fire = 1'b0;
    cyc(12);
    check("glitch", 32'(trig), 32'h0);
    fire = 1'b1;
    n = 0;
    while (trig !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    check("integration", 32'(n >= 5 && n <= 8), 32'h1);
    fire = 1'b0;
    cyc(60);
    check("lockout hold", 32'(trig), 32'h1);
    cyc(70);
    check("lockout end", 32'(trig), 32'h0);
  endtask : t_filter

  task automatic t_strobe();
    // Earlier scenarios already toggled line 3, so flashes count from here
    int base;
    base = flashes;
    wnode(ID_ORIGIN, 32'(SRC_STROBE));
    wnode(ID_LENGTH, 32'h5);
    wnode(ID_START, 32'(START_FTRIG));
    evt(1'b0, 1'b1);
    cyc(10);
    check("rejected trigger", 32'(flashes - base), 32'h0);
    evt(1'b0, 1'b0);
    cyc(10);
    check("frame trigger", 32'({4'(flashes - base), width[3:0]}), 32'h12);
    wnode(ID_START, 32'(START_EXPO));
    wnode(ID_DELAY, 32'h7D);
    wnode(ID_LENGTH, 32'h7D);
    tdly = 28'h000007D;
    evt(1'b1, 1'b1);
    n = 0;
    while (line3 !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    check("summed delay", 32'(n >= 99 && n <= 106), 32'h1);
    cyc(60);
    check("duration", 32'(width >= 48 && width <= 51), 32'h1);
    tdly = 28'h0000000;
    wnode(ID_DELAY, 32'h0);
    wnode(ID_LENGTH, 32'h5);
    wnode(ID_START, 32'(START_LINE0));
    hw_mode = 1'b1;
    rej = 1'b1;
    fire = 1'b1;
    cyc(20);
    check("line zero start", 32'(flashes - base), 32'h3);
    fire = 1'b0;
    rej = 1'b0;
    // Both lockout windows (rise and fall) must be over before the next edge
    cyc(230);
    hw_mode = 1'b0;
    fire = 1'b1;
    cyc(20);
    check("software mode", 32'(flashes - base), 32'h3);
    fire = 1'b0;
    wnode(ID_START, 32'(START_OFF));
    evt(1'b0, 1'b0);
    evt(1'b1, 1'b0);
    cyc(10);
    check("start off", 32'(flashes - base), 32'h3);
  endtask : t_strobe

  initial begin
    #1000000;
    bad_count++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    t_regs();
    t_lines();
    t_sources();
    t_filter();
    t_strobe();
    conclude();
  end
endmodule : camera_io_filter_strobe_bench
`default_nettype wire
